/* File: shared/sah_pkg.sv */
package sah_pkg;

  // ----------------------------------------------------------------
  // Register offsets within the three-byte window
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_CONTROL = 2'h0;  // Write: control, read: status
  localparam logic [1:0] OFS_DATA    = 2'h1;  // Write: command/parameter, read: reply
  localparam logic [1:0] OFS_INTR    = 2'h2;  // Read only

  // ----------------------------------------------------------------
  // Control bit positions
  // ----------------------------------------------------------------
  localparam int CTL_SCSI_BUS_RESET = 4;
  localparam int CTL_INT_ACK        = 5;
  localparam int CTL_SOFT_RESET     = 6;
  localparam int CTL_HARD_RESET     = 7;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int STS_BAD_COMMAND    = 0;
  localparam int STS_RESERVED       = 1;
  localparam int STS_REPLY_READY    = 2;
  localparam int STS_CMD_BUSY       = 3;
  localparam int STS_ADAPTER_READY  = 4;
  localparam int STS_INIT_REQUIRED  = 5;
  localparam int STS_SELFTEST_FAIL  = 6;
  localparam int STS_SELFTEST_RUN   = 7;

  // ----------------------------------------------------------------
  // Interrupt register bit positions and reset values
  // ----------------------------------------------------------------
  localparam int         INT_CMD_COMPLETE = 2;
  localparam int         INT_VALID        = 7;
  localparam logic [7:0] INTR_RESET       = 8'h00;
  localparam logic [7:0] BYTE_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          SCSI_RESET_NS     = 25000;
  localparam logic [11:0] SCSI_RESET_CYCLES =
    12'((SCSI_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] HALT_CYCLES       = 12'h010;

  typedef enum logic [1:0] {
    SAH_RUN,
    SAH_HALT,
    SAH_DIAG,
    SAH_FAILED
  } sah_state_t;

endpackage : sah_pkg

/* File: logic/sah_pulse_timer.sv */
`timescale 1ns/1ns
module sah_pulse_timer
  import sah_pkg::*;
#(
  parameter logic [11:0] CYCLES = 12'h001
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      active,
  output logic      done
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        active_q;
  logic        active_d;
  logic        done_q;
  logic        done_d;

  // A start while running reloads, so the pulse never ends early
  always_comb begin
    cnt_d    = cnt_q;
    active_d = active_q;
    done_d   = 1'b0;
    if (start) begin
      cnt_d    = CYCLES - 12'h001;
      active_d = 1'b1;
    end else if (active_q) begin
      if (cnt_q == 12'h000) begin
        active_d = 1'b0;
        done_d   = 1'b1;
      end else begin
        cnt_d = cnt_q - 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q    <= 12'h000;
      active_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      active_q <= active_d;
      done_q   <= done_d;
    end
  end

  assign active = active_q;
  assign done   = done_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [11:0] width_q;
  logic [11:0] width_d;

  // Saturates so a long chain of reloads cannot wrap the count
  always_comb begin
    width_d = 12'h000;
    if (active_q) begin
      width_d = (width_q == 12'hfff) ? width_q : width_q + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      width_q <= 12'h000;
    end else begin
      width_q <= width_d;
    end
  end

  a_pulse_min_width: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(active_q) |-> width_q >= CYCLES) else $error("Pulse released too early");

endmodule : sah_pulse_timer

/* File: logic/sah_host_regs.sv */
`timescale 1ns/1ns
module sah_host_regs
  import sah_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  output logic      [7:0] io_rdata,
  output logic            irq,
  output logic            scsi_reset_o,
  output logic            scsi_reset_oe,
  output logic            fw_halt,
  output logic            fw_selftest_req,
  output logic      [7:0] fw_cmd_byte,
  output logic            fw_cmd_valid,
  input  wire logic       fw_cmd_take,
  input  wire logic [7:0] fw_reply_byte,
  input  wire logic       fw_reply_load,
  input  wire logic       fw_cmd_done,
  input  wire logic       fw_cmd_bad,
  input  wire logic       fw_init_ok,
  input  wire logic       fw_diag_pass,
  input  wire logic       fw_diag_fail
);

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  logic        wr_ctrl, wr_cmd, rd_reply, hard_req;
  logic        soft_req, bus_req, ack_req;

  sah_state_t  state_q, state_d;
  logic        hard_q, hard_d;
  logic [7:4]  ctrl_q, ctrl_d;
  logic        busy_q, busy_d;
  logic [7:0]  cmd_q, cmd_d;
  logic        reply_rdy_q, reply_rdy_d;
  logic [7:0]  reply_q, reply_d;
  logic        bad_q, bad_d;
  logic        ready_q, ready_d;
  logic        init_q, init_d;
  logic        fail_q, fail_d;
  logic        run_q, run_d;
  logic [7:0]  intr_q, intr_d;
  logic        pend_q, pend_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        halt_q, halt_d;
  logic        diag_req_q, diag_req_d;
  logic        scsi_active, halt_done;
  logic [7:0]  status;

  assign wr_ctrl  = io_wr && (io_addr == OFS_CONTROL);
  assign wr_cmd   = io_wr && (io_addr == OFS_DATA) && !busy_q;
  assign rd_reply = io_rd && (io_addr == OFS_DATA);
  assign hard_req = wr_ctrl && io_wdata[CTL_HARD_RESET];
  assign soft_req = wr_ctrl && io_wdata[CTL_SOFT_RESET] && !hard_req;
  assign bus_req  = wr_ctrl && (io_wdata[CTL_SCSI_BUS_RESET] || hard_req);
  assign ack_req  = wr_ctrl && io_wdata[CTL_INT_ACK];

  // ----------------------------------------------------------------
  // Timers: SCSI reset pulse and adapter halt
  // ----------------------------------------------------------------
  sah_pulse_timer #(.CYCLES(SCSI_RESET_CYCLES)) u_scsi_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (bus_req),
    .active  (scsi_active),
    .done    ()
  );

  sah_pulse_timer #(.CYCLES(HALT_CYCLES)) u_halt_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (hard_req || soft_req),
    .active  (),
    .done    (halt_done)
  );

  // Reset line is a plain level; the SCSI engine drops every phase on it
  assign scsi_reset_o  = scsi_active;
  assign scsi_reset_oe = scsi_active;

  // ----------------------------------------------------------------
  // Reset sequencer and status
  // ----------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    hard_d      = hard_q;
    ctrl_d      = ctrl_q;
    busy_d      = busy_q;
    cmd_d       = cmd_q;
    reply_rdy_d = reply_rdy_q;
    reply_d     = reply_q;
    bad_d       = bad_q;
    ready_d     = ready_q;
    init_d      = init_q;
    fail_d      = fail_q;
    run_d       = run_q;
    intr_d      = intr_q;
    pend_d      = pend_q;

    // Command byte handshake; a write while busy is dropped
    if (wr_cmd) begin
      busy_d = 1'b1;
      cmd_d  = io_wdata;
      if (ready_q) begin
        ready_d = 1'b0;
        bad_d   = 1'b0;
      end
    end else if (fw_cmd_take) begin
      busy_d = 1'b0;
    end

    // Reply byte; a load in the read cycle keeps the flag set
    if (rd_reply) begin
      reply_rdy_d = 1'b0;
    end
    if (fw_reply_load) begin
      reply_rdy_d = 1'b1;
      reply_d     = fw_reply_byte;
    end

    if (fw_cmd_done) begin
      pend_d  = 1'b1;
      ready_d = 1'b1;
      if (fw_cmd_bad) begin
        bad_d = 1'b1;
      end
    end
    if (fw_init_ok) begin
      init_d = 1'b0;
    end

    // Completion waits until the register is clear and no reply pends
    if (ack_req) begin
      intr_d = INTR_RESET;
    end else if (pend_q && !intr_q[INT_VALID] && !reply_rdy_q) begin
      intr_d[INT_VALID]        = 1'b1;
      intr_d[INT_CMD_COMPLETE] = 1'b1;
      pend_d                   = fw_cmd_done;
    end

    if (bus_req) begin
      ctrl_d[CTL_SCSI_BUS_RESET] = 1'b1;
    end else if (!scsi_active) begin
      ctrl_d[CTL_SCSI_BUS_RESET] = 1'b0;
    end

    unique case (state_q)
      SAH_RUN, SAH_FAILED: ;
      SAH_HALT: begin
        if (halt_done) begin
          ctrl_d[CTL_SOFT_RESET] = 1'b0;
          ctrl_d[CTL_HARD_RESET] = 1'b0;
          if (hard_q) begin
            state_d = SAH_DIAG;
            run_d   = 1'b1;
          end else begin
            state_d = SAH_RUN;
            ready_d = 1'b1;
            init_d  = 1'b1;
          end
        end
      end
      SAH_DIAG: begin
        if (fw_diag_fail) begin
          state_d = SAH_FAILED;
          fail_d  = 1'b1;
        end else if (fw_diag_pass) begin
          state_d = SAH_RUN;
          run_d   = 1'b0;
          ready_d = 1'b1;
          init_d  = 1'b1;
        end
      end
    endcase

    // Either reset discards all queued work, overriding the above
    if (hard_req || soft_req) begin
      state_d     = SAH_HALT;
      hard_d      = hard_req;
      ctrl_d[CTL_SOFT_RESET] = soft_req;
      ctrl_d[CTL_HARD_RESET] = hard_req;
      busy_d      = 1'b0;
      reply_rdy_d = 1'b0;
      bad_d       = 1'b0;
      ready_d     = 1'b0;
      init_d      = 1'b0;
      intr_d      = INTR_RESET;
      pend_d      = 1'b0;
      if (hard_req) begin
        fail_d = 1'b0;
        run_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q     <= SAH_DIAG;
      hard_q      <= 1'b1;
      ctrl_q      <= 4'h0;
      busy_q      <= 1'b0;
      cmd_q       <= BYTE_RESET;
      reply_rdy_q <= 1'b0;
      reply_q     <= BYTE_RESET;
      bad_q       <= 1'b0;
      ready_q     <= 1'b0;
      init_q      <= 1'b0;
      fail_q      <= 1'b0;
      run_q       <= 1'b1;
      intr_q      <= INTR_RESET;
      pend_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      hard_q      <= hard_d;
      ctrl_q      <= ctrl_d;
      busy_q      <= busy_d;
      cmd_q       <= cmd_d;
      reply_rdy_q <= reply_rdy_d;
      reply_q     <= reply_d;
      bad_q       <= bad_d;
      ready_q     <= ready_d;
      init_q      <= init_d;
      fail_q      <= fail_d;
      run_q       <= run_d;
      intr_q      <= intr_d;
      pend_q      <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path and registered outputs
  // ----------------------------------------------------------------
  always_comb begin
    status                    = 8'h00;
    status[STS_BAD_COMMAND]   = bad_q;
    status[STS_RESERVED]      = 1'b0;
    status[STS_REPLY_READY]   = reply_rdy_q;
    status[STS_CMD_BUSY]      = busy_q;
    status[STS_ADAPTER_READY] = ready_q;
    status[STS_INIT_REQUIRED] = init_q;
    status[STS_SELFTEST_FAIL] = fail_q;
    status[STS_SELFTEST_RUN]  = run_q;
    rdata_d                   = rdata_q;
    // Reads only select; no read side effect touches written registers
    if (io_rd) begin
      unique case (io_addr)
        OFS_CONTROL: rdata_d = status;
        OFS_DATA:    rdata_d = reply_q;
        OFS_INTR:    rdata_d = intr_q;
        default:     rdata_d = 8'h00;
      endcase
    end
    halt_d     = (state_d == SAH_HALT);
    diag_req_d = (state_d == SAH_DIAG);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q    <= 8'h00;
      halt_q     <= 1'b0;
      diag_req_q <= 1'b1;
    end else begin
      rdata_q    <= rdata_d;
      halt_q     <= halt_d;
      diag_req_q <= diag_req_d;
    end
  end

  assign io_rdata        = rdata_q;
  assign irq             = intr_q[INT_VALID];
  assign fw_halt         = halt_q;
  assign fw_selftest_req = diag_req_q;
  assign fw_cmd_byte     = cmd_q;
  assign fw_cmd_valid    = busy_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_scsi_bit_drive: assert property (bus_req |=> scsi_reset_oe[*8])
    else $error("SCSI reset not driven after request");
  a_soft_no_scsi: assert property (soft_req && !bus_req && !scsi_active |=> !scsi_reset_oe)
    else $error("Soft reset drove SCSI reset");
  a_ack_clears: assert property (ack_req |=> intr_q == INTR_RESET && !irq)
    else $error("Acknowledge did not clear interrupt");
  a_irq_cause: assert property (irq |-> intr_q[INT_CMD_COMPLETE])
    else $error("Interrupt without cause bit");
  a_status_zero: assert property (
    io_rd && io_addr == OFS_CONTROL |=> !io_rdata[STS_RESERVED]) else $error("Reserved bit set");
  a_busy_sets: assert property (wr_cmd |=> fw_cmd_valid && fw_cmd_byte == $past(io_wdata))
    else $error("Command byte not latched as busy");
  a_reply_clear: assert property (rd_reply && !fw_reply_load |=> !reply_rdy_q)
    else $error("Reply ready not cleared by read");
  a_read_no_disturb: assert property (
    io_rd && !io_wr && !fw_cmd_take |=> $stable(fw_cmd_byte) && $stable(busy_q))
    else $error("Read disturbed command register");
  a_hard_halts: assert property (
    hard_req |=> fw_halt && !ready_q && !fail_q ##16 fw_halt) else $error("Hard reset halt lost");
  a_diag_pass: assert property (
    state_q == SAH_DIAG && fw_diag_pass && !fw_diag_fail && !wr_ctrl
    |=> ready_q && init_q && !run_q) else $error("Self-test pass not reported");
  a_fail_sticky: assert property (fail_q && !hard_req |=> fail_q)
    else $error("Self-test failure flag lost");

  c_cmd_irq: cover property (fw_cmd_done ##[1:20] irq);
  c_scsi_reset: cover property ($fell(scsi_reset_oe));
  c_soft_done: cover property (soft_req ##[1:40] (state_q == SAH_RUN && init_q));
  c_reply_read: cover property (fw_reply_load ##[1:10] rd_reply);

endmodule : sah_host_regs

/* File: bench/test_sah_host_regs.sv */
`timescale 1ns/1ns
module test_sah_host_regs;
  import sah_pkg::*;

  `define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e); end end

  // ----------------------------------------------------------------
  // Firmware event strobes, one bit each
  // ----------------------------------------------------------------
  localparam logic [6:0] EV_TAKE = 7'h40;
  localparam logic [6:0] EV_LOAD = 7'h20;
  localparam logic [6:0] EV_DONE = 7'h10;
  localparam logic [6:0] EV_INIT = 7'h08;
  localparam logic [6:0] EV_PASS = 7'h04;
  localparam logic [6:0] EV_FAIL = 7'h02;
  localparam logic [6:0] EV_BAD  = 7'h01;

  logic       clk;
  logic       reset_n;
  logic [1:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_rdata;
  logic       irq;
  logic       scsi_reset_o;
  logic       scsi_reset_oe;
  logic       fw_halt;
  logic       fw_selftest_req;
  logic [7:0] fw_cmd_byte;
  logic       fw_cmd_valid;
  logic [7:0] fw_reply_byte;
  logic [6:0] ev;
  logic       fw_cmd_take;
  logic       fw_reply_load;
  logic       fw_cmd_done;
  logic       fw_cmd_bad;
  logic       fw_init_ok;
  logic       fw_diag_pass;
  logic       fw_diag_fail;
  logic       saw;
  int         err_count;
  int         checked;
  int         cyc;
  int         n;

  assign {fw_cmd_take, fw_reply_load, fw_cmd_done, fw_init_ok,
          fw_diag_pass, fw_diag_fail, fw_cmd_bad} = ev;

  sah_host_regs dut (
    .clk             (clk),
    .reset_n         (reset_n),
    .io_addr         (io_addr),
    .io_wdata        (io_wdata),
    .io_wr           (io_wr),
    .io_rd           (io_rd),
    .io_rdata        (io_rdata),
    .irq             (irq),
    .scsi_reset_o    (scsi_reset_o),
    .scsi_reset_oe   (scsi_reset_oe),
    .fw_halt         (fw_halt),
    .fw_selftest_req (fw_selftest_req),
    .fw_cmd_byte     (fw_cmd_byte),
    .fw_cmd_valid    (fw_cmd_valid),
    .fw_cmd_take     (fw_cmd_take),
    .fw_reply_byte   (fw_reply_byte),
    .fw_reply_load   (fw_reply_load),
    .fw_cmd_done     (fw_cmd_done),
    .fw_cmd_bad      (fw_cmd_bad),
    .fw_init_ok      (fw_init_ok),
    .fw_diag_pass    (fw_diag_pass),
    .fw_diag_fail    (fw_diag_fail)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Host access and firmware tasks
  // ----------------------------------------------------------------
  task wrap_up;
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    #1;
  endtask : wr

  task rd_chk(input logic [1:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    `CHK(io_rdata, e, m)
  endtask : rd_chk

  task ev_pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask : ev_pulse

  // Records whether SCSI reset was ever driven while the halt lasted
  task wait_halt;
    saw = 1'b0;
    n   = 0;
    while (fw_halt === 1'b1 && n < 100) begin
      if (scsi_reset_oe !== 1'b0)
        saw = 1'b1;
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(fw_halt, 1'b0, "halt end")
  endtask : wait_halt

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n       = 1'b0;
    io_addr       = 2'h0;
    io_wdata      = 8'h00;
    io_wr         = 1'b0;
    io_rd         = 1'b0;
    fw_reply_byte = 8'h00;
    ev            = 7'h00;
    err_count     = 0;
    checked       = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK(fw_selftest_req, 1'b1, "selftest req")
    rd_chk(OFS_CONTROL, 8'h80, "status por");
    rd_chk(OFS_INTR, INTR_RESET, "intr por");
    rd_chk(2'h3, 8'h00, "unmapped");
    ev_pulse(EV_PASS);
    rd_chk(OFS_CONTROL, 8'h30, "status pass");
    // Reserved control bits do nothing
    wr(OFS_CONTROL, 8'h0f);
    `CHK(fw_halt, 1'b0, "rsv halt")
    rd_chk(OFS_CONTROL, 8'h30, "rsv status");
    // Command while ready, a dropped write while busy, then completion
    wr(OFS_DATA, 8'h01);
    `CHK(fw_cmd_valid, 1'b1, "busy set")
    `CHK(fw_cmd_byte, 8'h01, "cmd byte")
    rd_chk(OFS_CONTROL, 8'h28, "status busy");
    wr(OFS_DATA, 8'h55);
    `CHK(fw_cmd_byte, 8'h01, "busy drop")
    ev_pulse(EV_TAKE);
    rd_chk(OFS_CONTROL, 8'h20, "busy clear");
    ev_pulse(EV_INIT);
    rd_chk(OFS_CONTROL, 8'h00, "init clear");
    ev_pulse(EV_DONE | EV_BAD);
    rd_chk(OFS_CONTROL, 8'h11, "bad cmd");
    rd_chk(OFS_INTR, 8'h84, "cmd done");
    `CHK(irq, 1'b1, "irq up")
    wr(OFS_INTR, 8'h00);
    rd_chk(OFS_INTR, 8'h84, "intr ro");
    rd_chk(OFS_DATA, BYTE_RESET, "reply empty");
    `CHK(fw_cmd_byte, 8'h01, "read no disturb")
    wr(OFS_CONTROL, 8'h20);
    `CHK(irq, 1'b0, "ack irq")
    rd_chk(OFS_INTR, 8'h00, "ack intr");
    rd_chk(OFS_INTR, 8'h00, "ack stays");
    // Two reply bytes, ready flag per byte
    @(posedge clk) fw_reply_byte <= 8'ha5;
    ev_pulse(EV_LOAD);
    rd_chk(OFS_CONTROL, 8'h15, "reply ready");
    rd_chk(OFS_DATA, 8'ha5, "reply 1");
    rd_chk(OFS_CONTROL, 8'h11, "reply clear");
    @(posedge clk) fw_reply_byte <= 8'h3c;
    ev_pulse(EV_LOAD);
    rd_chk(OFS_DATA, 8'h3c, "reply 2");
    rd_chk(OFS_CONTROL, 8'h11, "reply clear 2");
    // A new command clears the stale bad flag; its completion stays pending
    wr(OFS_DATA, 8'h04);
    rd_chk(OFS_CONTROL, 8'h08, "new cmd");
    ev_pulse(EV_TAKE);
    ev_pulse(EV_DONE);
    rd_chk(OFS_CONTROL, 8'h10, "good cmd");
    rd_chk(OFS_INTR, 8'h84, "good done");
    // SCSI bus reset pulse width
    wr(OFS_CONTROL, 8'h10);
    `CHK(scsi_reset_oe, 1'b1, "scsi oe")
    `CHK(scsi_reset_o, 1'b1, "scsi level")
    `CHK(fw_halt, 1'b0, "scsi no halt")
    n = 0;
    while (scsi_reset_oe === 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, int'(SCSI_RESET_CYCLES), "scsi width")
    rd_chk(OFS_CONTROL, 8'h10, "scsi status");
    // Soft reset: halts, never touches SCSI reset, clears pending interrupt
    wr(OFS_CONTROL, 8'h40);
    `CHK(fw_halt, 1'b1, "soft halt")
    `CHK(irq, 1'b0, "soft irq")
    rd_chk(OFS_INTR, 8'h00, "soft intr");
    wait_halt();
    `CHK(saw, 1'b0, "soft no scsi")
    rd_chk(OFS_CONTROL, 8'h30, "soft done");
    // Hard reset with a failing, then a passing self-test
    wr(OFS_CONTROL, 8'h80);
    `CHK(scsi_reset_oe, 1'b1, "hard scsi")
    `CHK(fw_halt, 1'b1, "hard halt")
    wait_halt();
    `CHK(fw_selftest_req, 1'b1, "hard selftest")
    rd_chk(OFS_CONTROL, 8'h80, "hard diag");
    ev_pulse(EV_FAIL);
    rd_chk(OFS_CONTROL, 8'hc0, "diag fail");
    wr(OFS_CONTROL, 8'h80);
    wait_halt();
    rd_chk(OFS_CONTROL, 8'h80, "fail cleared");
    ev_pulse(EV_PASS);
    rd_chk(OFS_CONTROL, 8'h30, "hard done");
    wrap_up();
  end

endmodule : test_sah_host_regs
